// ==== include/rvs_pkg.sv ====
// ****************************************************************
// Shared constants for the reset and vector address selector
// ****************************************************************
package rvs_pkg;

    // Word address width of program memory (4K words)
    localparam int ADDR_W = 12;
    // Number of interrupt sources, vector numbers 2 to 19
    localparam int IRQ_N = 18;
    // Width of a vector number
    localparam int VNO_W = 5;

    // ****************************************************************
    // Fixed addresses and counts
    // ****************************************************************
    // Reset target while the boot fuse is unprogrammed
    localparam logic [ADDR_W-1:0] RESET_ADDR    = 12'h000;
    // Table start relative to its base
    localparam logic [ADDR_W-1:0] VEC_TABLE_OFS = 12'h001;
    // Cycles the unlock bit stays set
    localparam logic [2:0]        UNLOCK_CYCLES = 3'h4;
    // Fuse level that means programmed
    localparam logic              FUSE_PROGRAMMED = 1'h0;

    // ****************************************************************
    // Vector numbers, lowest number is highest priority
    // ****************************************************************
    localparam logic [VNO_W-1:0] VNO_RESET                    = 5'h01;
    localparam logic [VNO_W-1:0] VNO_EXTERNAL_REQUEST_ZERO    = 5'h02;
    localparam logic [VNO_W-1:0] VNO_EXTERNAL_REQUEST_ONE     = 5'h03;
    localparam logic [VNO_W-1:0] VNO_TIMER_TWO_MATCH          = 5'h04;
    localparam logic [VNO_W-1:0] VNO_TIMER_TWO_WRAP           = 5'h05;
    localparam logic [VNO_W-1:0] VNO_TIMER_ONE_CAPTURE        = 5'h06;
    localparam logic [VNO_W-1:0] VNO_TIMER_ONE_MATCH_A        = 5'h07;
    localparam logic [VNO_W-1:0] VNO_TIMER_ONE_MATCH_B        = 5'h08;
    localparam logic [VNO_W-1:0] VNO_TIMER_ONE_WRAP           = 5'h09;
    localparam logic [VNO_W-1:0] VNO_TIMER_ZERO_WRAP          = 5'h0A;
    localparam logic [VNO_W-1:0] VNO_SERIAL_TRANSFER_DONE     = 5'h0B;
    localparam logic [VNO_W-1:0] VNO_RECEIVE_DONE             = 5'h0C;
    localparam logic [VNO_W-1:0] VNO_TRANSMIT_BUFFER_EMPTY    = 5'h0D;
    localparam logic [VNO_W-1:0] VNO_TRANSMIT_DONE            = 5'h0E;
    localparam logic [VNO_W-1:0] VNO_CONVERSION_DONE          = 5'h0F;
    localparam logic [VNO_W-1:0] VNO_NONVOLATILE_DATA_READY   = 5'h10;
    localparam logic [VNO_W-1:0] VNO_COMPARATOR_EVENT         = 5'h11;
    localparam logic [VNO_W-1:0] VNO_TWO_WIRE_EVENT           = 5'h12;
    localparam logic [VNO_W-1:0] VNO_SELF_PROGRAM_STORE_READY = 5'h13;

    // Request bit k of the source vector maps to vector number k + 2
    localparam logic [VNO_W-1:0] VNO_FIRST_IRQ = VNO_EXTERNAL_REQUEST_ZERO;

    // ****************************************************************
    // Types
    // ****************************************************************
    // Relocation unlock sequence
    typedef enum logic [1:0] {
        RVS_OPEN,
        RVS_UNLOCKED,
        RVS_SETTLE
    } rvs_lock_t;

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Vector address: table base plus vector number less one
    function automatic logic [ADDR_W-1:0] rvs_vec_addr(
        input logic [ADDR_W-1:0] base,
        input logic [VNO_W-1:0]  vno
    );
        logic [ADDR_W-1:0] ofs;
        ofs = {{(ADDR_W-VNO_W){1'b0}}, vno} - VEC_TABLE_OFS;
        return base + ofs;
    endfunction

endpackage

// ==== verilog/rvs_prio.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Fixed priority picker, bit 0 wins
// ****************************************************************
module rvs_prio #(
    parameter int N  = 18,
    parameter int IW = 5
) (
    // Requests
    input  wire logic [N-1:0]  i_req,
    // Result
    output logic               o_found,
    output logic [IW-1:0]      o_index,
    output logic [N-1:0]       o_onehot
);

    // ****************************************************************
    // Search from the top down so the lowest set bit is kept
    // ****************************************************************
    always_comb begin
        o_found  = 1'b0;
        o_index  = '0;
        o_onehot = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (i_req[k]) begin
                o_found  = 1'b1;
                o_index  = IW'(k);
                o_onehot = N'(1) << k;
            end
        end
    end

endmodule
`default_nettype wire

// ==== verilog/rvs_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1: Any reset source jumps to vector one
// R2: External requests zero, one at 0x001, 0x002
// R3: Timer vectors fill 0x003 to 0x009 in order
// R4: Serial vectors fill 0x00A to 0x00D in order
// R5: Remaining vectors 0x00E to 0x012 in order
// R6: Relocation adds boot start to each interrupt vector
// R7: Programmed boot fuse moves reset to boot start
// R8: Reset address and table base chosen independently
// R9: Relocation write needs unlock within four cycles
// R10: Unlock window blocks interrupt acceptance, I-bit untouched
// R11: Lowest pending vector number wins
// R12: Boot start address is a configuration input
module rvs_top
    import rvs_pkg::*;
(
    // Clock and reset
    input  wire logic                        I_CLK,
    input  wire logic                        I_RESET_N,
    // Configuration
    input  wire logic                        I_BOOT_START_FUSE,
    input  wire logic [rvs_pkg::ADDR_W-1:0]  I_BOOT_BASE,
    // Reset sources: pin, power-on, brown-out, watchdog
    input  wire logic [3:0]                  I_RESET_SRC,
    // Write to the general irq control bits
    input  wire logic                        I_CTRL_WR,
    input  wire logic                        I_VECTOR_MOVE_UNLOCK,
    input  wire logic                        I_VECTOR_TABLE_IN_BOOT,
    // Core status
    input  wire logic                        I_GLOBAL_EN,
    input  wire logic                        I_INSTR_RETIRE,
    // Pending enabled requests, bit 0 is vector two
    input  wire logic [rvs_pkg::IRQ_N-1:0]   I_IRQ_REQ,
    // Jump request to the fetch logic
    output logic                             O_JUMP_VALID,
    output logic [rvs_pkg::ADDR_W-1:0]       O_JUMP_ADDR,
    output logic [rvs_pkg::VNO_W-1:0]        O_JUMP_VECTOR,
    // Acknowledge to the accepted requester
    output logic [rvs_pkg::IRQ_N-1:0]        O_IRQ_ACK,
    // Control state read back
    output logic                             O_VECTOR_TABLE_IN_BOOT,
    output logic                             O_VECTOR_MOVE_UNLOCK,
    output logic                             O_IRQ_BLOCKED
);
    import rvs_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        rvs_lock_t           lock;        // Unlock sequence phase
        logic [2:0]          count;       // Cycles left in unlock window
        logic                in_boot;     // Vector table relocated
        logic                unlock;      // Unlock bit read back
        logic                blocked;     // Acceptance held off
        logic                reset_pend;  // Reset jump still owed
        logic                jump_valid;  // Jump pulse
        logic [ADDR_W-1:0]   jump_addr;   // Jump target
        logic [VNO_W-1:0]    jump_vec;    // Jump vector number
        logic [IRQ_N-1:0]    ack;         // One-hot acknowledge
    } rvs_state_t;

    // Value after any chip reset: table low, reset jump owed
    localparam rvs_state_t ST_RESET = '{
        lock:       RVS_OPEN,
        count:      3'h0,
        in_boot:    1'b0,
        unlock:     1'b0,
        blocked:    1'b0,
        reset_pend: 1'b1,
        jump_valid: 1'b0,
        jump_addr:  RESET_ADDR,
        jump_vec:   VNO_RESET,
        ack:        '0
    };

    rvs_state_t          s_q;             // Registered state
    rvs_state_t          s_d;             // Next state

    // ****************************************************************
    // Priority pick among pending requests
    // ****************************************************************
    logic                pick_found;      // Any request pending
    logic [VNO_W-1:0]    pick_index;      // Bit index of the winner
    logic [IRQ_N-1:0]    pick_onehot;     // Winner as one-hot

    // Lowest bit, i.e. lowest vector number, wins
    rvs_prio #(
        .N  (IRQ_N),
        .IW (VNO_W)
    ) u_prio (
        .i_req    (I_IRQ_REQ),
        .o_found  (pick_found),
        .o_index  (pick_index),
        .o_onehot (pick_onehot)
    ); // R11

    // ****************************************************************
    // Address selection
    // ****************************************************************
    logic [ADDR_W-1:0]   reset_target;    // Where execution starts
    logic [ADDR_W-1:0]   table_base;      // Base of the vector table
    logic [VNO_W-1:0]    pick_vno;        // Winner's vector number
    logic                unlock_write;    // Write that arms the unlock
    logic                move_write;      // Write that moves the table
    logic                block_now;       // Acceptance held this cycle
    logic                take_irq;        // Interrupt accepted

    always_comb begin
        // Fuse picks the reset target on its own
        if (I_BOOT_START_FUSE == FUSE_PROGRAMMED) begin
            reset_target = I_BOOT_BASE; // R7 R12
        end else begin
            reset_target = RESET_ADDR; // R1 R7
        end
        // Relocation picks the table base on its own
        if (s_q.in_boot) begin
            table_base = I_BOOT_BASE; // R6 R8 R12
        end else begin
            table_base = RESET_ADDR; // R8
        end
    end

    // Vector numbers start at two for request bit zero; table order
    // in the package fixes every source address.
    assign pick_vno = pick_index + VNO_FIRST_IRQ; // R2 R3 R4 R5

    // ****************************************************************
    // Unlock and acceptance gating
    // ****************************************************************
    // Writing the unlock bit as one always (re)arms the window
    assign unlock_write = I_CTRL_WR && I_VECTOR_MOVE_UNLOCK; // R9
    // Only a write with the unlock bit clear, inside the window, moves
    assign move_write = I_CTRL_WR && !I_VECTOR_MOVE_UNLOCK
                        && (s_q.lock == RVS_UNLOCKED); // R9

    // Blocking starts in the very cycle the unlock is written, which
    // is why the raw write strobe is folded in here.
    assign block_now = (s_q.lock != RVS_OPEN) || unlock_write; // R10

    // Taken only at an instruction boundary with the I-bit set; the
    // I-bit is only read here, never altered.
    assign take_irq = pick_found && I_GLOBAL_EN && I_INSTR_RETIRE
                      && !block_now && !s_q.reset_pend
                      && !s_q.jump_valid; // R10

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d            = s_q;
        s_d.jump_valid = 1'b0;
        s_d.ack        = '0;

        // Unlock sequence
        case (s_q.lock)
            RVS_OPEN: begin
                // Idle, waiting for an unlock write
                if (unlock_write) begin
                    s_d.lock  = RVS_UNLOCKED;
                    s_d.count = UNLOCK_CYCLES - 3'h1; // R9
                end
            end
            RVS_UNLOCKED: begin
                if (move_write) begin
                    // Move the table, drop unlock, block one more instr
                    s_d.in_boot = I_VECTOR_TABLE_IN_BOOT; // R9
                    s_d.lock    = RVS_SETTLE; // R10
                    s_d.count   = 3'h0;
                end else if (unlock_write) begin
                    // Rewrite of unlock restarts the window
                    s_d.count = UNLOCK_CYCLES - 3'h1;
                end else if (s_q.count == 3'h0) begin
                    // Window closed with no move, table unchanged
                    s_d.lock = RVS_OPEN; // R9 R10
                end else begin
                    s_d.count = s_q.count - 3'h1;
                end
            end
            RVS_SETTLE: begin
                // Released once the following instruction retires
                if (unlock_write) begin
                    s_d.lock  = RVS_UNLOCKED;
                    s_d.count = UNLOCK_CYCLES - 3'h1;
                end else if (I_INSTR_RETIRE) begin
                    s_d.lock = RVS_OPEN; // R10
                end
            end
            default: begin
                // Unreachable encoding falls back to idle
                s_d.lock = RVS_OPEN;
            end
        endcase
        s_d.blocked = (s_d.lock != RVS_OPEN); // R10
        // Kept as its own flop so the read-back port has no decode
        s_d.unlock  = (s_d.lock == RVS_UNLOCKED); // R9

        // Jump generation, reset first
        if (s_q.reset_pend) begin
            s_d.reset_pend = 1'b0;
            s_d.jump_valid = 1'b1;
            s_d.jump_addr  = reset_target; // R1 R7 R8
            s_d.jump_vec   = VNO_RESET; // R1
        end else if (take_irq) begin
            s_d.jump_valid = 1'b1;
            s_d.jump_addr  = rvs_vec_addr(table_base, pick_vno); // R6 R8
            s_d.jump_vec   = pick_vno; // R11
            s_d.ack        = pick_onehot; // R11
        end

        // Any reset source restarts the block; the jump follows next
        if (|I_RESET_SRC) begin
            s_d = ST_RESET; // R1
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Synchronous reset loads constants only
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            s_q <= ST_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs, all straight from the state register
    // ****************************************************************
    assign O_JUMP_VALID           = s_q.jump_valid;
    assign O_JUMP_ADDR            = s_q.jump_addr;
    assign O_JUMP_VECTOR          = s_q.jump_vec;
    assign O_IRQ_ACK              = s_q.ack;
    assign O_VECTOR_TABLE_IN_BOOT = s_q.in_boot;
    assign O_VECTOR_MOVE_UNLOCK   = s_q.unlock;
    assign O_IRQ_BLOCKED          = s_q.blocked;

endmodule
`default_nettype wire

// ==== verification/rvs_src_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Interrupt requesters: requests stay pending until acknowledged
// ****************************************************************
module rvs_src_model
    import rvs_pkg::*;
(
    // Clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_reset_n,
    // Raise pulses from the bench, acknowledge from the block
    input  wire logic [rvs_pkg::IRQ_N-1:0] i_raise,
    input  wire logic [rvs_pkg::IRQ_N-1:0] i_ack,
    // Pending requests
    output logic      [rvs_pkg::IRQ_N-1:0] o_req
);
    // Sticky request, dropped only by its own acknowledge or by reset
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_req <= '0;
        end else begin
            o_req <= (o_req | i_raise) & ~i_ack;
        end
    end
endmodule
`default_nettype wire

// ==== verification/rvs_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Port checker for the vector selector
// ****************************************************************
module rvs_chk
    import rvs_pkg::*;
(
    // Inputs of the block
    input wire logic                       I_CLK,
    input wire logic                       I_RESET_N,
    input wire logic                       I_BOOT_START_FUSE,
    input wire logic [rvs_pkg::ADDR_W-1:0] I_BOOT_BASE,
    input wire logic [3:0]                 I_RESET_SRC,
    input wire logic                       I_CTRL_WR,
    input wire logic                       I_VECTOR_MOVE_UNLOCK,
    input wire logic                       I_VECTOR_TABLE_IN_BOOT,
    input wire logic                       I_GLOBAL_EN,
    input wire logic                       I_INSTR_RETIRE,
    input wire logic [rvs_pkg::IRQ_N-1:0]  I_IRQ_REQ,
    // Outputs of the block
    input wire logic                       O_JUMP_VALID,
    input wire logic [rvs_pkg::ADDR_W-1:0] O_JUMP_ADDR,
    input wire logic [rvs_pkg::VNO_W-1:0]  O_JUMP_VECTOR,
    input wire logic [rvs_pkg::IRQ_N-1:0]  O_IRQ_ACK,
    input wire logic                       O_VECTOR_TABLE_IN_BOOT,
    input wire logic                       O_VECTOR_MOVE_UNLOCK,
    input wire logic                       O_IRQ_BLOCKED
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    reset_jump_a: assert property ($rose(I_RESET_N) |=> O_JUMP_VALID &&
        O_JUMP_VECTOR == VNO_RESET && O_JUMP_ADDR ==
        ($past(I_BOOT_START_FUSE) ? RESET_ADDR : $past(I_BOOT_BASE))) else $error("reset jump");
    src_jump_a: assert property (|I_RESET_SRC |=> !O_JUMP_VALID ##1 O_JUMP_VALID &&
        O_JUMP_VECTOR == VNO_RESET && O_JUMP_ADDR ==
        ($past(I_BOOT_START_FUSE) ? RESET_ADDR : $past(I_BOOT_BASE))) else $error("source jump");
    irq_take_a: assert property (I_INSTR_RETIRE && I_GLOBAL_EN && |I_IRQ_REQ &&
        !O_IRQ_BLOCKED && !O_JUMP_VALID && !(I_CTRL_WR && I_VECTOR_MOVE_UNLOCK) &&
        !(|I_RESET_SRC) && !$past(|I_RESET_SRC) && $past(I_RESET_N) |=> O_JUMP_VALID &&
        O_IRQ_ACK == ($past(I_IRQ_REQ) & (~$past(I_IRQ_REQ) + 18'h1))) else $error("accept");
    irq_addr_a: assert property (O_JUMP_VALID && |O_IRQ_ACK |->
        O_IRQ_ACK == (18'h1 << (O_JUMP_VECTOR - VNO_FIRST_IRQ)) && O_JUMP_ADDR ==
        12'((O_VECTOR_TABLE_IN_BOOT ? I_BOOT_BASE : RESET_ADDR) + O_JUMP_VECTOR - 12'h001))
        else $error("vector address");
    unlock_len_a: assert property ((I_CTRL_WR && I_VECTOR_MOVE_UNLOCK) ##1
        (!I_CTRL_WR && !(|I_RESET_SRC))[*4] |=> !O_VECTOR_MOVE_UNLOCK && !O_IRQ_BLOCKED &&
        $past(O_VECTOR_MOVE_UNLOCK) && $past(O_VECTOR_MOVE_UNLOCK, 4)) else $error("window");
    move_takes_a: assert property (I_CTRL_WR && !I_VECTOR_MOVE_UNLOCK &&
        O_VECTOR_MOVE_UNLOCK && !(|I_RESET_SRC) |=> !O_VECTOR_MOVE_UNLOCK && O_IRQ_BLOCKED &&
        O_VECTOR_TABLE_IN_BOOT == $past(I_VECTOR_TABLE_IN_BOOT)) else $error("move");
    block_hold_a: assert property (O_IRQ_BLOCKED || (I_CTRL_WR && I_VECTOR_MOVE_UNLOCK)
        |=> O_IRQ_ACK == 18'h0) else $error("accepted while blocked");
    block_end_a: assert property (O_IRQ_BLOCKED && !O_VECTOR_MOVE_UNLOCK &&
        I_INSTR_RETIRE && !I_CTRL_WR |=> !O_IRQ_BLOCKED) else $error("block kept");

    // Main scenarios reached
    cover property (O_JUMP_VALID && O_VECTOR_TABLE_IN_BOOT && |O_IRQ_ACK);
    cover property ($fell(O_VECTOR_MOVE_UNLOCK) && O_IRQ_BLOCKED);
    cover property (|I_RESET_SRC ##2 O_JUMP_VALID);
endmodule

bind rvs_top rvs_chk rvs_chk_i (.*);
`default_nettype wire

// ==== verification/tb_reset_and_vector_address_select.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin num_errors++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); end end
// ****************************************************************
// Bench: reset, table, priority, relocation
// ****************************************************************
module tb_reset_and_vector_address_select;
    import rvs_pkg::*;
    logic        clk, rst_n, fuse, wr, unl, inb, gen, ret, jv, o_inb, o_unl, o_blk;
    logic [11:0] base, ja;
    logic [3:0]  src;
    logic [4:0]  jvec;
    logic [17:0] raise, req, ack;
    int          num_errors, samples_checked;

    always #2.5 clk = ~clk;

    rvs_src_model rvs_src_model_i (.i_clk(clk), .i_reset_n(rst_n), .i_raise(raise),
        .i_ack(ack), .o_req(req));
    rvs_top rvs_top_i (.I_CLK(clk), .I_RESET_N(rst_n), .I_BOOT_START_FUSE(fuse),
        .I_BOOT_BASE(base), .I_RESET_SRC(src), .I_CTRL_WR(wr), .I_VECTOR_MOVE_UNLOCK(unl),
        .I_VECTOR_TABLE_IN_BOOT(inb), .I_GLOBAL_EN(gen), .I_INSTR_RETIRE(ret),
        .I_IRQ_REQ(req), .O_JUMP_VALID(jv), .O_JUMP_ADDR(ja), .O_JUMP_VECTOR(jvec),
        .O_IRQ_ACK(ack), .O_VECTOR_TABLE_IN_BOOT(o_inb), .O_VECTOR_MOVE_UNLOCK(o_unl),
        .O_IRQ_BLOCKED(o_blk));

    // Inputs move 1 ns after the edge
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Bounded wait for a jump pulse, then its target
    task automatic wait_jump(input logic [11:0] ea, input logic [4:0] ev);
        for (int n = 0; n < 8 && jv !== 1'b1; n++) tick();
        `CHK("jump valid", 1'b1, jv)
        if (jv !== 1'b1) wrap_up();
        `CHK("jump addr", ea, ja)
        `CHK("jump vector", ev, jvec)
    endtask
    // Raise mask, retire one instruction, expect source k
    task automatic take_irq(input logic [17:0] mask, input int k, input logic [11:0] tb);
        raise = mask;
        tick();
        raise = 18'h0;
        ret = 1'b1;
        tick();
        ret = 1'b0;
        wait_jump(tb + 12'(k + 1), 5'(k + 2));
        `CHK("ack", 18'h1 << k, ack)
        tick();
    endtask
    // Control write; caller lowers the strobe
    task automatic ctrl(input logic u, input logic v);
        wr = 1'b1;
        unl = u;
        inb = v;
        tick();
    endtask

    initial begin
        clk = 1'b0; rst_n = 1'b0; fuse = 1'b1; base = 12'hC00; src = 4'h0; wr = 1'b0;
        unl = 1'b0; inb = 1'b0; gen = 1'b1; ret = 1'b0; raise = 18'h0;
        num_errors = 0; samples_checked = 0;
        tick(16);
        rst_n = 1'b1;
        wait_jump(12'h000, 5'h01);
        tick();
        for (int k = 0; k < IRQ_N; k++) take_irq(18'h1 << k, k, 12'h000);
        take_irq(18'h20028, 3, 12'h000);
        take_irq(18'h0, 5, 12'h000);
        take_irq(18'h0, 17, 12'h000);
        gen = 1'b0;
        raise = 18'h1;
        tick();
        raise = 18'h0;
        ret = 1'b1;
        tick();
        ret = 1'b0;
        gen = 1'b1;
        `CHK("disabled jump", 1'b0, jv)
        take_irq(18'h0, 0, 12'h000);
        $display("table and priority done");
        ctrl(1'b1, 1'b0);
        ctrl(1'b0, 1'b1);
        wr = 1'b0;
        `CHK("in boot", 1'b1, o_inb)
        `CHK("unlock cleared", 1'b0, o_unl)
        `CHK("blocked", 1'b1, o_blk)
        raise = 18'h1;
        tick();
        raise = 18'h0;
        ret = 1'b1;
        tick();
        ret = 1'b0;
        `CHK("refused jump", 1'b0, jv)
        `CHK("block released", 1'b0, o_blk)
        tick();
        take_irq(18'h0, 0, 12'hC00);
        take_irq(18'h20000, 17, 12'hC00);
        $display("relocation done");
        raise = 18'h4;
        ctrl(1'b1, 1'b0);
        wr = 1'b0;
        raise = 18'h0;
        ret = 1'b1;
        tick();
        ret = 1'b0;
        `CHK("window jump", 1'b0, jv)
        tick(2);
        `CHK("unlock c4", 1'b1, o_unl)
        tick();
        `CHK("unlock expired", 1'b0, o_unl)
        `CHK("block expired", 1'b0, o_blk)
        ctrl(1'b0, 1'b0);
        wr = 1'b0;
        `CHK("late move", 1'b1, o_inb)
        tick();
        take_irq(18'h0, 2, 12'hC00);
        $display("window done");
        for (int s = 0; s < 4; s++) begin
            fuse = s[0];
            tick();
            src = 4'h1 << s;
            tick();
            src = 4'h0;
            wait_jump(s[0] ? 12'h000 : 12'hC00, 5'h01);
            tick();
        end
        `CHK("in boot after reset", 1'b0, o_inb)
        take_irq(18'h2, 1, 12'h000);
        fuse = 1'b0;
        base = 12'h800;
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        wait_jump(12'h800, 5'h01);
        $display("reset sources done");
        tick(2);
        wrap_up();
    end
endmodule
`default_nettype wire
